// ### welk_pkg.sv
// Purpose : shared constants and types for the word encode / align link
// Assumes : one clock domain, MCLK at 200 MHz, one serial bit per clock
// Notes   : code-field assignment and flag scrambler are agreed by both ends
package welk_pkg;
    // ------------------------------------------------------------------
    // word geometry
    // ------------------------------------------------------------------
    localparam int WORD_BITS  = 16;
    localparam int CODE_BITS  = 4;
    localparam int LINE_BITS  = 20;
    localparam int CTRL_BITS  = 14;
    localparam logic [4:0] LAST_BIT = 5'h13;

    // ------------------------------------------------------------------
    // code-field patterns (non-inverted form), inversion complements all
    // ------------------------------------------------------------------
    localparam logic [3:0] CF_DATA_F0 = 4'h3;
    localparam logic [3:0] CF_DATA_F1 = 4'h5;
    localparam logic [3:0] CF_CTRL    = 4'h6;
    localparam logic [3:0] CF_IDLE    = 4'h1; // complement must not alias other codes
    localparam logic [15:0] IDLE_WORD = 16'hFF00;

    // ------------------------------------------------------------------
    // alignment timing, in words
    // ------------------------------------------------------------------
    localparam logic [5:0] FLAG_WINDOW  = 6'h20;
    localparam logic [7:0] READY_WORDS  = 8'h40;
    localparam logic [6:0] SCRAM_SEED   = 7'h55; // alternating top bit gives early flips

    // ------------------------------------------------------------------
    // rate bands and word classes
    // ------------------------------------------------------------------
    localparam logic [1:0] BAND_DIV1 = 2'h0;
    localparam logic [1:0] BAND_DIV2 = 2'h1;
    localparam logic [1:0] BAND_DIV4 = 2'h2;
    localparam logic [1:0] BAND_TEST = 2'h3;

    typedef enum logic [1:0] {WK_DATA, WK_CTRL, WK_IDLE, WK_ERR} welk_kind_t;

    // next state of the shared flag scrambler
    function automatic logic [6:0] scram_next(input logic [6:0] s);
        scram_next = {s[5:0], s[6] ^ s[5]};
    endfunction : scram_next
endpackage : welk_pkg

// ### welk_word_if.sv
// Purpose : carries one 20-bit line word between serializer and coder
// Assumes : single clock
// Notes   : strobe is a one-cycle pulse per word
`timescale 1ns/1ps
`default_nettype none
interface welk_word_if;
    logic [19:0] word;
    logic        strobe;
    modport src (output word, output strobe);
    modport dst (input word, input strobe);
endinterface : welk_word_if
`default_nettype wire

// ### welk_ser.sv
// Purpose : 20-bit word to serial shifter, bit 0 first
// Assumes : one bit per MCLK edge
// Notes   : strobes a request for the next word on bit 18, one before the last
`timescale 1ns/1ps
`default_nettype none
module welk_ser (
    input  wire logic MCLK,
    input  wire logic RST,
    welk_word_if.dst  wi,
    output var  logic sout,
    output var  logic need
);
    logic [19:0] sh_q;
    logic [4:0]  cnt_q;

    // ------------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------------
    // load on strobe, else shift
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sh_q  <= 20'h00000;
            cnt_q <= 5'h00;
            sout  <= 1'b0;
            need  <= 1'b0;
        end
        else
        begin
            // request two bits early: strobe lands right after bit 19
            need <= (cnt_q == welk_pkg::LAST_BIT - 5'h02);
            if (wi.strobe)
            begin
                sout  <= wi.word[0];
                sh_q  <= {1'b0, wi.word[19:1]};
                cnt_q <= 5'h00;
            end
            else
            begin
                sout  <= sh_q[0];
                sh_q  <= {1'b0, sh_q[19:1]};
                cnt_q <= (cnt_q == welk_pkg::LAST_BIT) ? 5'h00 : cnt_q + 5'h01;
            end
        end
    end
endmodule : welk_ser
`default_nettype wire

// ### welk_des.sv
// Purpose : serial to 20-bit word demultiplexer with one-bit slip
// Assumes : one bit per MCLK edge, input already synchronised
// Notes   : a slip holds the bit counter one extra cycle
`timescale 1ns/1ps
`default_nettype none
module welk_des (
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic sin,
    input  wire logic slip,
    welk_word_if.src  wo
);
    logic [19:0] sh_q;
    logic [4:0]  cnt_q;
    logic        slip_q;

    // ------------------------------------------------------------------
    // collector
    // ------------------------------------------------------------------
    // bit 0 arrives first; word strobed after bit 19
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sh_q      <= 20'h00000;
            cnt_q     <= 5'h00;
            slip_q    <= 1'b0;
            wo.word   <= 20'h00000;
            wo.strobe <= 1'b0;
        end
        else
        begin
            sh_q      <= {sin, sh_q[19:1]};
            wo.strobe <= 1'b0;
            if (slip)
                slip_q <= 1'b1;
            if (slip_q)
                slip_q <= 1'b0; // hold count: boundary moves one bit
            else if (cnt_q == welk_pkg::LAST_BIT)
            begin
                cnt_q     <= 5'h00;
                wo.word   <= {sin, sh_q[19:1]};
                wo.strobe <= 1'b1;
            end
            else
                cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule : welk_des
`default_nettype wire

// ### welk_link.sv
// Purpose : word encoder with disparity control and receive word aligner
// Assumes : MCLK is the bit clock; word rate is MCLK over 20
// Notes   : code field sits in line bits 19:16, word field in 15:0
`timescale 1ns/1ps
`default_nettype none
module welk_link (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        TX_WORD_CLOCK,
    input  wire logic        EXTERNAL_SERIAL_CLOCK_ENABLE,
    input  wire logic [1:0]  TX_RATE_BAND_SELECT,
    input  wire logic [15:0] TX_DATA_IN,
    input  wire logic        CONTROL_WORD_REQUEST,
    input  wire logic        DATA_WORD_REQUEST,
    input  wire logic        TX_USER_FLAG,
    input  wire logic        TX_FLAG_DATA_ENABLE,
    input  wire logic        FLAG_SCRAMBLE_ENABLE,
    input  wire logic [1:0]  RX_RATE_BAND_SELECT,
    input  wire logic        SERIAL_INPUT_PAIR,
    input  wire logic        SERIAL_TEST_CLOCK,
    input  wire logic        LOCAL_REFERENCE_CLOCK,
    input  wire logic        RX_FLAG_DATA_ENABLE,
    input  wire logic        ALIGNMENT_DISABLE,
    output logic             SERIAL_OUT,
    output logic             TX_PLL_LOCK_FLAG,
    output logic             TX_WORD_TAKEN,
    output logic [1:0]       TX_BAND_DIVIDE,
    output logic [15:0]      RX_DATA_OUT,
    output logic             RX_USER_FLAG,
    output logic             RX_DATA_WORD_FLAG,
    output logic             RX_CONTROL_WORD_FLAG,
    output logic             RX_DECODE_ERROR,
    output logic             RX_WORD_STROBE,
    output logic             RX_WORD_READY,
    output logic             RX_BIT_SLIP,
    output logic             RX_WORD_CLOCKS,
    output logic             RX_REF_LOCK
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sy_wclk_q, sy_sin_q, sy_tst_q, sy_ref_q;
    logic       wclk_prev_q, ref_prev_q;

    // two flops per pin input
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sy_wclk_q <= 2'h0;
            sy_sin_q  <= 2'h0;
            sy_tst_q  <= 2'h0;
            sy_ref_q  <= 2'h0;
        end
        else
        begin
            sy_wclk_q <= {sy_wclk_q[0], TX_WORD_CLOCK};
            sy_sin_q  <= {sy_sin_q[0], SERIAL_INPUT_PAIR};
            sy_tst_q  <= {sy_tst_q[0], SERIAL_TEST_CLOCK};
            sy_ref_q  <= {sy_ref_q[0], LOCAL_REFERENCE_CLOCK};
        end
    end

    // ------------------------------------------------------------------
    // transmit clocking and lock
    // ------------------------------------------------------------------
    logic [4:0] bits_q;
    logic [1:0] lock_cnt_q;
    logic       wclk_rise, ext_bit, ser_need, ser_out;
    assign wclk_rise = sy_wclk_q[1] & ~wclk_prev_q;

    // bit count per word
    // counts 20 bit clocks between word-clock edges to detect lock
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            wclk_prev_q      <= 1'b0;
            bits_q           <= 5'h00;
            lock_cnt_q       <= 2'h0;
            TX_PLL_LOCK_FLAG <= 1'b0;
            TX_BAND_DIVIDE   <= 2'h0;
        end
        else
        begin
            wclk_prev_q <= sy_wclk_q[1];
            unique case (TX_RATE_BAND_SELECT)
                welk_pkg::BAND_DIV1: TX_BAND_DIVIDE <= 2'h0;
                welk_pkg::BAND_DIV2: TX_BAND_DIVIDE <= 2'h1;
                welk_pkg::BAND_DIV4: TX_BAND_DIVIDE <= 2'h2;
                welk_pkg::BAND_TEST: TX_BAND_DIVIDE <= 2'h3;
            endcase
            if (wclk_rise)
            begin
                bits_q <= 5'h00;
                if (bits_q == welk_pkg::LAST_BIT)
                    lock_cnt_q <= (lock_cnt_q == 2'h3) ? 2'h3 : lock_cnt_q + 2'h1;
                else
                    lock_cnt_q <= 2'h0;
            end
            else if (bits_q != 5'h1F)
                bits_q <= bits_q + 5'h01;
            TX_PLL_LOCK_FLAG <= (lock_cnt_q == 2'h3) & ~EXTERNAL_SERIAL_CLOCK_ENABLE;
        end
    end

    // external clock mode
    // word clock pin rising edge gates the word load; the shifter still moves one bit per MCLK
    assign ext_bit = EXTERNAL_SERIAL_CLOCK_ENABLE ? wclk_rise : 1'b1;

    // ------------------------------------------------------------------
    // transmit encoder
    // ------------------------------------------------------------------
    welk_word_if tx_w ();
    logic signed [7:0] disp_q;
    logic [6:0]        tx_scr_q;
    logic              alt_q;
    logic [19:0]       enc_w;
    logic              flag_bit;
    logic signed [5:0] wdisp;

    // control / data / idle / word build
    always_comb
    begin
        flag_bit = TX_FLAG_DATA_ENABLE ? TX_USER_FLAG : alt_q; // alternation
        if (FLAG_SCRAMBLE_ENABLE)
            flag_bit = flag_bit ^ tx_scr_q[6];
        if (CONTROL_WORD_REQUEST)
            enc_w = {welk_pkg::CF_CTRL, 2'h0, TX_DATA_IN[13:0]};
        else if (DATA_WORD_REQUEST)
            enc_w = {flag_bit ? welk_pkg::CF_DATA_F1 : welk_pkg::CF_DATA_F0, TX_DATA_IN};
        else
            enc_w = {welk_pkg::CF_IDLE, welk_pkg::IDLE_WORD};
    end

    always_comb
    begin
        wdisp = -6'sd20;
        for (int i = 0; i < welk_pkg::LINE_BITS; i++)
            wdisp = wdisp + (enc_w[i] ? 6'sd2 : 6'sd0);
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            disp_q      <= 8'sh00;
            tx_scr_q    <= welk_pkg::SCRAM_SEED;
            alt_q       <= 1'b0;
            tx_w.word   <= 20'h00000;
            tx_w.strobe <= 1'b0;
        end
        else
        begin
            tx_w.strobe <= ser_need & ext_bit;
            if (ser_need & ext_bit)
            begin
                alt_q    <= ~alt_q;
                // scrambler restarts on every non-data word, both ends alike
                if (DATA_WORD_REQUEST && !CONTROL_WORD_REQUEST)
                    tx_scr_q <= welk_pkg::scram_next(tx_scr_q);
                else
                    tx_scr_q <= welk_pkg::SCRAM_SEED;
                if ((disp_q > 8'sh00) == (wdisp > 6'sh00) && wdisp != 6'sh00)
                begin
                    tx_w.word <= ~enc_w;
                    disp_q    <= disp_q - 8'(wdisp);
                end
                else
                begin
                    tx_w.word <= enc_w;
                    disp_q    <= disp_q + 8'(wdisp);
                end
            end
        end
    end

    welk_ser u_ser (
        .MCLK (MCLK),
        .RST  (RST),
        .wi   (tx_w),
        .sout (ser_out),
        .need (ser_need)
    );

    // serial out and word-taken pulse registered
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            SERIAL_OUT    <= 1'b0;
            TX_WORD_TAKEN <= 1'b0;
        end
        else
        begin
            SERIAL_OUT    <= ser_out;
            TX_WORD_TAKEN <= tx_w.strobe;
        end
    end

    // ------------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------------
    welk_word_if rx_w ();
    logic        rx_sin, slip_req;
    logic [19:0] rw;
    logic [3:0]  cf;
    logic        inv;
    welk_pkg::welk_kind_t kind;
    logic        rflag;

    assign rx_sin = (RX_RATE_BAND_SELECT == welk_pkg::BAND_TEST) ? sy_tst_q[1] : sy_sin_q[1];

    welk_des u_des (
        .MCLK (MCLK),
        .RST  (RST),
        .sin  (rx_sin),
        .slip (slip_req),
        .wo   (rx_w)
    );

    always_comb
    begin
        cf   = rx_w.word[19:16];
        inv  = 1'b0;
        kind = welk_pkg::WK_ERR;
        rflag = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            if ((k[0] ? ~cf : cf) == welk_pkg::CF_DATA_F0 ||
                (k[0] ? ~cf : cf) == welk_pkg::CF_DATA_F1)
            begin
                kind  = welk_pkg::WK_DATA;
                inv   = k[0];
                rflag = ((k[0] ? ~cf : cf) == welk_pkg::CF_DATA_F1);
            end
            else if ((k[0] ? ~cf : cf) == welk_pkg::CF_CTRL)
            begin
                kind = welk_pkg::WK_CTRL;
                inv  = k[0];
            end
            else if ((k[0] ? ~cf : cf) == welk_pkg::CF_IDLE)
            begin
                kind = welk_pkg::WK_IDLE;
                inv  = k[0];
            end
        end
        rw = inv ? ~rx_w.word : rx_w.word;
    end

    // ------------------------------------------------------------------
    // alignment and outputs
    // ------------------------------------------------------------------
    logic [6:0] rx_scr_q;
    logic       err_prev_q, alt_exp_q, sflag_prev_q, seen_tr_q, seen_dat_q;
    logic [5:0] win_q;
    logic [7:0] quiet_q;
    logic       raw_err, tr_miss;

    // alternating flag checked when receiver flag and flag scrambling are both disabled
    assign raw_err = (kind == welk_pkg::WK_ERR) ||
                     (kind == welk_pkg::WK_DATA && !RX_FLAG_DATA_ENABLE &&
                      !FLAG_SCRAMBLE_ENABLE && rflag != alt_exp_q);
    assign tr_miss = FLAG_SCRAMBLE_ENABLE && win_q == welk_pkg::FLAG_WINDOW - 6'h01 &&
                     !seen_tr_q && (seen_dat_q || kind == welk_pkg::WK_DATA) &&
                     !(kind == welk_pkg::WK_DATA && rflag != sflag_prev_q);
    // two errors / window / disable
    assign slip_req = rx_w.strobe && !ALIGNMENT_DISABLE &&
                      ((raw_err && err_prev_q) || tr_miss);

    // word-rate tracking and ready
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            err_prev_q   <= 1'b0;
            alt_exp_q    <= 1'b0;
            sflag_prev_q <= 1'b0;
            seen_tr_q    <= 1'b0;
            seen_dat_q   <= 1'b0;
            win_q        <= 6'h00;
            quiet_q      <= 8'h00;
            rx_scr_q     <= welk_pkg::SCRAM_SEED;
            RX_WORD_READY <= 1'b0;
            RX_BIT_SLIP  <= 1'b0;
        end
        else
        begin
            RX_BIT_SLIP <= slip_req;
            if (rx_w.strobe)
            begin
                err_prev_q <= raw_err & ~slip_req;
                alt_exp_q  <= (kind == welk_pkg::WK_DATA) ? ~rflag : ~alt_exp_q;
                if (kind == welk_pkg::WK_DATA)
                    rx_scr_q <= welk_pkg::scram_next(rx_scr_q);
                else
                    rx_scr_q <= welk_pkg::SCRAM_SEED;
                // windows with no data word carry no flag to judge
                if (win_q == welk_pkg::FLAG_WINDOW - 6'h01)
                    seen_dat_q <= 1'b0;
                else if (kind == welk_pkg::WK_DATA)
                    seen_dat_q <= 1'b1;
                if (kind == welk_pkg::WK_DATA)
                    sflag_prev_q <= rflag;
                win_q <= (win_q == welk_pkg::FLAG_WINDOW - 6'h01) ? 6'h00 : win_q + 6'h01;
                if (win_q == welk_pkg::FLAG_WINDOW - 6'h01)
                    seen_tr_q <= 1'b0;
                else if (kind == welk_pkg::WK_DATA && rflag != sflag_prev_q)
                    seen_tr_q <= 1'b1;
                if (slip_req)
                    quiet_q <= 8'h00;
                else if (quiet_q != welk_pkg::READY_WORDS)
                    quiet_q <= quiet_q + 8'h01;
            end
            if (slip_req)
                RX_WORD_READY <= 1'b0;
            else if (quiet_q == welk_pkg::READY_WORDS)
                RX_WORD_READY <= 1'b1;
        end
    end

    // control mark / descramble / error output
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            RX_DATA_OUT          <= 16'h0000;
            RX_USER_FLAG         <= 1'b0;
            RX_DATA_WORD_FLAG    <= 1'b0;
            RX_CONTROL_WORD_FLAG <= 1'b0;
            RX_DECODE_ERROR      <= 1'b0;
            RX_WORD_STROBE       <= 1'b0;
            RX_WORD_CLOCKS       <= 1'b0;
            RX_REF_LOCK          <= 1'b0;
            ref_prev_q           <= 1'b0;
        end
        else
        begin
            RX_WORD_STROBE <= rx_w.strobe;
            ref_prev_q     <= sy_ref_q[1];
            RX_REF_LOCK    <= sy_ref_q[1] ^ ref_prev_q ? 1'b1 : RX_REF_LOCK;
            if (rx_w.strobe)
            begin
                RX_WORD_CLOCKS       <= ~RX_WORD_CLOCKS;
                RX_DECODE_ERROR      <= (kind == welk_pkg::WK_ERR);
                RX_DATA_WORD_FLAG    <= (kind == welk_pkg::WK_DATA);
                RX_CONTROL_WORD_FLAG <= (kind == welk_pkg::WK_CTRL);
                if (kind == welk_pkg::WK_CTRL)
                    RX_DATA_OUT <= {2'h0, rw[13:0]};
                else if (kind == welk_pkg::WK_DATA)
                    RX_DATA_OUT <= rw[15:0];
                if (kind == welk_pkg::WK_DATA)
                    RX_USER_FLAG <= FLAG_SCRAMBLE_ENABLE ? rflag ^ rx_scr_q[6] : rflag;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    ready_drop_a: assert property (@(posedge MCLK) disable iff (RST)
        slip_req |=> !RX_WORD_READY) else $error("ready not dropped on slip");
    slip_disable_a: assert property (@(posedge MCLK) disable iff (RST)
        ALIGNMENT_DISABLE |-> !slip_req) else $error("slip while disabled");
    ctrl_mark_a: assert property (@(posedge MCLK) disable iff (RST)
        rx_w.strobe && kind == welk_pkg::WK_CTRL |=> RX_CONTROL_WORD_FLAG && RX_DATA_OUT[15:14] == 2'h0)
        else $error("control word not marked");
    err_out_a: assert property (@(posedge MCLK) disable iff (RST)
        rx_w.strobe && kind == welk_pkg::WK_ERR |=> RX_DECODE_ERROR) else $error("error not flagged");
    ctrl_prio_a: assert property (@(posedge MCLK) disable iff (RST)
        CONTROL_WORD_REQUEST |-> enc_w[19:16] == welk_pkg::CF_CTRL) else $error("control lost");
    data_word_a: assert property (@(posedge MCLK) disable iff (RST)
        !CONTROL_WORD_REQUEST && DATA_WORD_REQUEST |-> enc_w[15:0] == TX_DATA_IN)
        else $error("data word wrong");
    idle_word_a: assert property (@(posedge MCLK) disable iff (RST)
        !CONTROL_WORD_REQUEST && !DATA_WORD_REQUEST |-> enc_w[15:0] == welk_pkg::IDLE_WORD)
        else $error("idle word wrong");
    test_input_a: assert property (@(posedge MCLK) disable iff (RST)
        RX_RATE_BAND_SELECT == welk_pkg::BAND_TEST |-> rx_sin == sy_tst_q[1])
        else $error("test clock not used");
    slip_c: cover property (@(posedge MCLK) disable iff (RST) slip_req);
    ready_c: cover property (@(posedge MCLK) disable iff (RST) $rose(RX_WORD_READY));
    ctrl_c: cover property (@(posedge MCLK) disable iff (RST) RX_CONTROL_WORD_FLAG);
endmodule : welk_link
`default_nettype wire

// ### welk_far.sv
// Purpose : far-end model, word and reference clocks, serial loopback
// Assumes : MCLK is the bit clock, word rate is MCLK over 20
// Notes   : skew adds one bit of line delay to force a realignment
`timescale 1ns/1ps
`default_nettype none
module welk_far (
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic SOUT,
    input  wire logic SKEW,
    output var  logic SIN,
    output var  logic TX_WORD_CLOCK,
    output var  logic LOCAL_REFERENCE_CLOCK
);
    logic [3:0] cnt_q;
    logic [1:0] dly_q;
    // ------------------------------------------------------------------
    // clocks and line
    // ------------------------------------------------------------------
    // word-rate clock, ten bits high and ten low
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cnt_q         <= 4'h0;
            TX_WORD_CLOCK <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
            TX_WORD_CLOCK <= (cnt_q == 4'h9) ? ~TX_WORD_CLOCK : TX_WORD_CLOCK;
        end
    end
    always_ff @(posedge MCLK)
    begin
        dly_q <= {dly_q[0], SOUT};
    end
    assign SIN    = SKEW ? dly_q[1] : dly_q[0];
    assign LOCAL_REFERENCE_CLOCK = TX_WORD_CLOCK; // reference runs at word rate
endmodule : welk_far
`default_nettype wire

// ### tb.sv
// Purpose : self-checking bench for the link coder and aligner
// Assumes : serial output looped back through the far-end model
// Notes   : every scenario waits under a bounded count
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0, rst = 1'b1, skew = 1'b0, sin, wclk, rclk, sout;
    logic [1:0] band = 2'h0, bdiv;
    logic [15:0] dat = 16'h0, rdat;
    logic creq = 0, dreq = 0, uflag = 0, fen = 0, sen = 0, rfen = 0, adis = 0;
    logic lock, taken, rflag, rdw, rcw, rerr, rstb, rrdy, rslip, rwclk, rlk;
    int miscompares = 0, cmp_count = 0, cyc = 0, n;
    always #2.5 mclk = ~mclk;
    welk_far welk_far_inst (.MCLK(mclk), .RST(rst), .SOUT(sout), .SKEW(skew),
        .SIN(sin), .TX_WORD_CLOCK(wclk), .LOCAL_REFERENCE_CLOCK(rclk));
    welk_link welk_link_inst (.MCLK(mclk), .RST(rst), .TX_WORD_CLOCK(wclk),
        .EXTERNAL_SERIAL_CLOCK_ENABLE(1'b0), .TX_RATE_BAND_SELECT(band),
        .TX_DATA_IN(dat), .CONTROL_WORD_REQUEST(creq), .DATA_WORD_REQUEST(dreq),
        .TX_USER_FLAG(uflag), .TX_FLAG_DATA_ENABLE(fen), .FLAG_SCRAMBLE_ENABLE(sen),
        .RX_RATE_BAND_SELECT(2'h0), .SERIAL_INPUT_PAIR(sin), .SERIAL_TEST_CLOCK(1'b0),
        .LOCAL_REFERENCE_CLOCK(rclk), .RX_FLAG_DATA_ENABLE(rfen),
        .ALIGNMENT_DISABLE(adis), .SERIAL_OUT(sout), .TX_PLL_LOCK_FLAG(lock),
        .TX_WORD_TAKEN(taken), .TX_BAND_DIVIDE(bdiv), .RX_DATA_OUT(rdat),
        .RX_USER_FLAG(rflag), .RX_DATA_WORD_FLAG(rdw), .RX_CONTROL_WORD_FLAG(rcw),
        .RX_DECODE_ERROR(rerr), .RX_WORD_STROBE(rstb), .RX_WORD_READY(rrdy),
        .RX_BIT_SLIP(rslip), .RX_WORD_CLOCKS(rwclk), .RX_REF_LOCK(rlk));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task summarize;
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    // wait at falling edges for a word strobe of the given kind
    task wait_kind(input logic [1:0] k);
        for (n = 0; !(rstb === 1'b1 && {rcw, rdw} === k) && n < 400; n++) @(negedge mclk);
        chk({15'h0, rstb}, 16'h1);
        chk({15'h0, rerr}, 16'h0);
    endtask : wait_kind
    task wait_ready;
        for (n = 0; rrdy !== 1'b1 && n < 9000; n++) @(negedge mclk);
        chk({15'h0, rrdy}, 16'h1);
    endtask : wait_ready
    task xfer(input logic c, d, f, input logic [15:0] v, m, e);
        @(posedge mclk);
        {creq, dreq, uflag, dat} <= {c, d, f, v};
        wait_kind({c, d & ~c});
        chk(rdat & m, e);
        if (fen) chk({15'h0, rflag}, {15'h0, f});
        @(posedge mclk);
        {creq, dreq} <= 2'h0;
        wait_kind(2'h0);
    endtask : xfer
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_band;
        for (int b = 0; b < 4; b++)
        begin
            @(posedge mclk);
            band <= b[1:0];
            repeat (4) @(negedge mclk);
            chk({14'h0, bdiv}, b[15:0]);
        end
    endtask : t_band
    task t_words;
        wait_ready();
        chk({15'h0, lock}, 16'h1);
        chk({15'h0, rlk}, 16'h1);
        xfer(1'b0, 1'b1, 1'b0, 16'hA5C3, 16'hFFFF, 16'hA5C3);
        xfer(1'b1, 1'b1, 1'b0, 16'hC123, 16'h3FFF, 16'h0123);
        {fen, rfen} <= 2'h3;
        xfer(1'b0, 1'b1, 1'b1, 16'h0F0F, 16'hFFFF, 16'h0F0F);
        sen <= 1'b1;
        xfer(1'b0, 1'b1, 1'b1, 16'hFFFF, 16'hFFFF, 16'hFFFF);
        xfer(1'b0, 1'b1, 1'b0, 16'h0000, 16'hFFFF, 16'h0000);
    endtask : t_words
    task t_slip;
        @(posedge mclk);
        {adis, skew} <= 2'h3;
        for (n = 0; n < 400; n++) @(negedge mclk) chk({15'h0, rslip}, 16'h0);
        @(posedge mclk);
        adis <= 1'b0;
        for (n = 0; rslip !== 1'b1 && n < 400; n++) @(negedge mclk);
        chk({15'h0, rslip}, 16'h1);
        @(negedge mclk);
        chk({15'h0, rrdy}, 16'h0);
        wait_ready();
        xfer(1'b0, 1'b1, 1'b0, 16'h1234, 16'hFFFF, 16'h1234);
    endtask : t_slip
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_band();
        t_words();
        t_slip();
        summarize();
    end
endmodule : tb
`default_nettype wire
